// ===== hdl/i2cbsr_regs.svh
`ifndef I2CBSR_REGS_SVH
`define I2CBSR_REGS_SVH

// ***************************************
// Register map
// ***************************************
`define I2CBSR_ADDR_W 12
`define I2CBSR_CMD_OFS 12'h004
`define I2CBSR_PHASE_OFS 12'h008

// Command register, write-one pulses
`define I2CBSR_CMD_START_BIT 0
`define I2CBSR_CMD_ABORT_BIT 1

// Bus phase register fields
`define I2CBSR_PH_MSB 7
`define I2CBSR_PH_LSB 5
`define I2CBSR_STALL_BIT 4
`define I2CBSR_REFUSE_BIT 3
`define I2CBSR_TX_BIT 2
`define I2CBSR_MASTER_BIT 1
`define I2CBSR_BUSY_BIT 0
`define I2CBSR_BUSY_RST 1'b1

// Phase encodings
`define I2CBSR_PH_IDLE 3'h0
`define I2CBSR_PH_WAIT 3'h1
`define I2CBSR_PH_START 3'h2
`define I2CBSR_PH_ADDR 3'h3
`define I2CBSR_PH_ID_HANDSHAKE_PHASE 3'h4
`define I2CBSR_PH_DATA 3'h5
`define I2CBSR_PH_BYTE_HANDSHAKE_PHASE 3'h6

// Bits per byte on the line
`define I2CBSR_BYTE_BITS 4'h8
`define I2CBSR_CNT_ZERO 4'h0
`define I2CBSR_CNT_ONE 4'h1

`endif

// ===== hdl/i2cbsr_pkg.sv
package i2cbsr_pkg;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_WAIT,
    PH_START,
    PH_ADDR,
    PH_ID_HANDSHAKE,
    PH_DATA,
    PH_BYTE_HANDSHAKE
  } i2cbsr_phase_type;
endpackage : i2cbsr_pkg

// ===== hdl/i2cbsr_line_sync.sv
module i2cbsr_line_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Asynchronous lines
  input wire logic [WIDTH-1:0] line_in,
  // Synchronised level and edges
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic prev_q;
      // Idle lines sit high, so reset to one
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          prev_q <= 1'b1;
        end else begin
          meta_q <= line_in[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign level_out[g] = sync_q;
      assign rise_out[g] = sync_q & ~prev_q;
      assign fall_out[g] = ~sync_q & prev_q;
    end
  endgenerate
endmodule : i2cbsr_line_sync

// ===== hdl/i2cbsr_top.sv
// Behaviour
// - Phase field bits 7:5 encodes idle..byte handshake; zero whenever idle.
// - Refusal flag set only for a NACK seen in a handshake phase.
// - Transmitter flag set as master or slave transmitter, else clear.
// - Busy flag set from a start condition by anyone until stop, abort command or idle timeout.
// - Busy flag resets to one since bus state is unknown.
// - Abort command or bus idle timeout clears the busy indication.
// - Abort abandons the current transfer at once and clears busy.
`include "i2cbsr_regs.svh"

module i2cbsr_top
  import i2cbsr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`I2CBSR_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // I2C lines, observed only
  input wire logic scl_in,
  input wire logic sda_in,
  // Shifting datapath, same clock
  input wire logic slave_selected_in,
  input wire logic scl_hold_in,
  input wire logic idle_timeout_in,
  // To the shifting datapath
  output logic start_pending_out,
  output logic abort_out,
  output logic bus_busy_out
);

  // ***************************************
  // Reset release
  // ***************************************
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // ***************************************
  // Line sampling
  // ***************************************
  logic [1:0] line_lvl;
  logic [1:0] line_rise;
  logic [1:0] line_fall;
  i2cbsr_line_sync #(.WIDTH(2)) u_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .line_in({sda_in, scl_in}),
    .level_out(line_lvl),
    .rise_out(line_rise),
    .fall_out(line_fall)
  );
  wire scl_hi = line_lvl[0];
  wire scl_rise = line_rise[0];
  wire scl_fall = line_fall[0];
  wire sda_lvl = line_lvl[1];
  // SDA moving while SCL high marks a frame boundary
  wire start_seen = scl_hi & line_fall[1];
  wire stop_seen = scl_hi & line_rise[1];

  // ***************************************
  // APB decode
  // ***************************************
  wire setup_ph = psel_in & ~penable_in;
  wire access_ph = psel_in & penable_in;
  wire hit_cmd = paddr_in == `I2CBSR_CMD_OFS;
  wire hit_phase = paddr_in == `I2CBSR_PHASE_OFS;
  wire hit_any = hit_cmd | hit_phase;
  wire cmd_wr = access_ph & pwrite_in & hit_cmd;
  // Upper command bits are ignored; software keeps them zero
  wire start_cmd = cmd_wr & pwdata_in[`I2CBSR_CMD_START_BIT];
  wire abort_cmd = cmd_wr & pwdata_in[`I2CBSR_CMD_ABORT_BIT];
  // Phase register is read only, a write to it is refused
  assign pready_out = 1'b1;
  assign pslverr_out = access_ph & (~hit_any | (pwrite_in & hit_phase));

  // ***************************************
  // Phase tracking
  // ***************************************
  i2cbsr_phase_type phase_q;
  i2cbsr_phase_type phase_d;
  logic [3:0] bit_cnt_q;
  logic busy_q;
  logic master_q;
  logic start_pend_q;
  logic rw_q;
  logic refuse_q;
  logic stall_q;

  wire byte_done = scl_fall & (bit_cnt_q == `I2CBSR_BYTE_BITS);
  wire in_handshake = (phase_q == PH_ID_HANDSHAKE) | (phase_q == PH_BYTE_HANDSHAKE);
  wire ends_frame = abort_cmd | idle_timeout_in;

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_IDLE: begin
        if (start_seen) begin
          phase_d = PH_START;
        end else if (start_pend_q && busy_q) begin
          phase_d = PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (start_seen) begin
          phase_d = PH_START;
        end
      end
      PH_START: begin
        if (scl_fall) begin
          phase_d = PH_ADDR;
        end
      end
      PH_ADDR: begin
        if (byte_done) begin
          phase_d = PH_ID_HANDSHAKE;
        end
      end
      PH_ID_HANDSHAKE: begin
        if (scl_fall) begin
          // Not addressed and not master: transfer is none of ours
          phase_d = (master_q || slave_selected_in) ? PH_DATA : PH_IDLE;
        end
      end
      PH_DATA: begin
        if (byte_done) begin
          phase_d = PH_BYTE_HANDSHAKE;
        end
      end
      PH_BYTE_HANDSHAKE: begin
        if (scl_fall) begin
          phase_d = PH_DATA;
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
    // Boundaries override the byte walk
    if (phase_q != PH_IDLE && phase_q != PH_WAIT && start_seen) begin
      phase_d = PH_START;
    end
    if (stop_seen) begin
      phase_d = start_pend_q ? PH_WAIT : PH_IDLE;
    end
    if (abort_cmd) begin
      phase_d = PH_IDLE;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Bit counter, cleared on each byte boundary
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= `I2CBSR_CNT_ZERO;
    end else if (start_seen || phase_d != phase_q) begin
      bit_cnt_q <= `I2CBSR_CNT_ZERO;
    end else if (scl_rise) begin
      bit_cnt_q <= bit_cnt_q + `I2CBSR_CNT_ONE;
    end
  end

  // Direction bit is the eighth address bit
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rw_q <= 1'b0;
    end else if (phase_q == PH_ADDR && scl_rise &&
                 bit_cnt_q == (`I2CBSR_BYTE_BITS - `I2CBSR_CNT_ONE)) begin
      rw_q <= sda_lvl;
    end
  end

  // ***************************************
  // Busy, start request, master role
  // ***************************************
  // Unknown bus after reset is treated as busy
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= `I2CBSR_BUSY_RST;
    end else if (start_seen) begin
      busy_q <= 1'b1;
    end else if (stop_seen || ends_frame) begin
      busy_q <= 1'b0;
    end
  end

  // Request sticks until our start goes out; a new request wins over the abort
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      start_pend_q <= 1'b0;
    end else if (start_cmd) begin
      start_pend_q <= 1'b1;
    end else if (start_seen || abort_cmd) begin
      start_pend_q <= 1'b0;
    end
  end

  // A start seen while our request stands is taken as ours
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      master_q <= 1'b0;
    end else if (stop_seen || ends_frame) begin
      master_q <= 1'b0;
    end else if (start_seen) begin
      master_q <= master_q | start_pend_q;
    end
  end

  // ***************************************
  // Refusal and stall flags
  // ***************************************
  // Ninth clock high samples the handshake bit
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      refuse_q <= 1'b0;
    end else if (phase_d != phase_q) begin
      refuse_q <= 1'b0;
    end else if (in_handshake && scl_rise) begin
      refuse_q <= sda_lvl;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      stall_q <= 1'b0;
    end else begin
      stall_q <= scl_hold_in & (phase_d != PH_IDLE) & ~abort_cmd;
    end
  end

  // ***************************************
  // Role decode and register image
  // ***************************************
  wire addr_part = (phase_q == PH_START) | (phase_q == PH_ADDR) |
                   (phase_q == PH_ID_HANDSHAKE);
  wire data_part = (phase_q == PH_DATA) | (phase_q == PH_BYTE_HANDSHAKE);
  // Master sends the address then writes if rw low; slave sends when rw high
  wire as_master_tx = master_q & (addr_part | (data_part & ~rw_q));
  wire as_slave_tx = ~master_q & slave_selected_in & data_part & rw_q;
  wire tx_flag = as_master_tx | as_slave_tx;
  wire refusal_seen_flag = refuse_q & in_handshake;

  logic [2:0] phase_code;
  always_comb begin
    case (phase_q)
      PH_IDLE: phase_code = `I2CBSR_PH_IDLE;
      PH_WAIT: phase_code = `I2CBSR_PH_WAIT;
      PH_START: phase_code = `I2CBSR_PH_START;
      PH_ADDR: phase_code = `I2CBSR_PH_ADDR;
      PH_ID_HANDSHAKE: phase_code = `I2CBSR_PH_ID_HANDSHAKE_PHASE;
      PH_DATA: phase_code = `I2CBSR_PH_DATA;
      PH_BYTE_HANDSHAKE: phase_code = `I2CBSR_PH_BYTE_HANDSHAKE_PHASE;
      default: phase_code = `I2CBSR_PH_IDLE;
    endcase
  end

  logic [31:0] phase_img;
  always_comb begin
    phase_img = 32'h0000_0000;
    phase_img[`I2CBSR_PH_MSB:`I2CBSR_PH_LSB] = phase_code;
    phase_img[`I2CBSR_STALL_BIT] = stall_q;
    phase_img[`I2CBSR_REFUSE_BIT] = refusal_seen_flag;
    phase_img[`I2CBSR_TX_BIT] = tx_flag;
    phase_img[`I2CBSR_MASTER_BIT] = master_q;
    phase_img[`I2CBSR_BUSY_BIT] = busy_q;
  end

  wire [31:0] cmd_img = {30'h0000_0000, abort_cmd, start_pend_q};
  wire [31:0] rd_mux = hit_phase ? phase_img : (hit_cmd ? cmd_img : 32'h0000_0000);

  // Read data is captured in the setup cycle
  logic [31:0] prdata_q;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_in) begin
      prdata_q <= rd_mux;
    end
  end

  logic abort_q;
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_cmd;
    end
  end

  assign prdata_out = prdata_q;
  assign start_pending_out = start_pend_q;
  assign abort_out = abort_q;
  assign bus_busy_out = busy_q;

  // ***************************************
  // Checks
  // ***************************************
  a_idle_phase_zero: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    (phase_q == PH_IDLE) |-> (phase_img[`I2CBSR_PH_MSB:`I2CBSR_PH_LSB] == 3'h0))
    else $error("phase field not zero while idle");

  a_refusal_in_handshake: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    phase_img[`I2CBSR_REFUSE_BIT] |-> (phase_code == 3'h4 || phase_code == 3'h6))
    else $error("refusal flag outside handshake");

  a_tx_needs_role: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    tx_flag |-> (master_q || slave_selected_in) && phase_q != PH_IDLE)
    else $error("transmitter flag without a role");

  a_master_drops_stop: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    stop_seen && !start_seen |=> !master_q)
    else $error("master flag survives stop");

  a_busy_on_start: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    start_seen |=> busy_q && bus_busy_out)
    else $error("start did not mark bus busy");

  a_busy_after_reset: assert property (
    @(posedge core_clk_in)
    $rose(rst_n) |-> busy_q)
    else $error("busy not set after reset");

  a_timeout_clears: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    (idle_timeout_in && !start_seen) |=> !busy_q ##0 !master_q)
    else $error("idle timeout left busy");

  a_stall_follows: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    !scl_hold_in |=> !stall_q)
    else $error("stall flag without hold");

  a_abort_idles: assert property (
    @(posedge core_clk_in) disable iff (!rst_n)
    (abort_cmd && !start_seen) |=> phase_q == PH_IDLE && !busy_q && abort_out
    ##1 !abort_out)
    else $error("abort did not idle the block");

endmodule : i2cbsr_top

// ===== test/i2cbsr_bus_partner.sv
module i2cbsr_bus_partner (
  // Bus lines, pulled up when released
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Odd skew keeps line edges off the core clock grid
  task automatic start_cond();
    #3.3;
    sda_out = 1'b1;
    scl_out = 1'b1;
    #40;
    sda_out = 1'b0;
    #40;
  endtask : start_cond

  // One 80 ns bit; returns with the clock line high
  task automatic put_bit(input logic b);
    scl_out = 1'b0;
    #20;
    sda_out = b;
    #20;
    scl_out = 1'b1;
    #40;
  endtask : put_bit

  task automatic put_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
  endtask : put_byte

  task automatic stop_cond();
    put_bit(1'b0);
    sda_out = 1'b1;
    #40;
  endtask : stop_cond
endmodule : i2cbsr_bus_partner

// ===== test/i2c_bus_state_reporting_tb.sv
`include "i2cbsr_regs.svh"

module i2c_bus_state_reporting_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, scl, sda, start_pend, abort_p, busy, er;
  logic sel = 1'b0;
  logic hold = 1'b0;
  logic tmo = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int aborts = 0;
  int seed = 32'hea5cebe8;

  always #2.5 clk = ~clk;

  i2cbsr_top DUT (
    .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda),
    .slave_selected_in(sel), .scl_hold_in(hold), .idle_timeout_in(tmo),
    .start_pending_out(start_pend), .abort_out(abort_p), .bus_busy_out(busy));

  i2cbsr_bus_partner P (.scl_out(scl), .sda_out(sda));

  // ********
  // Helpers
  // ********
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Ceiling far above the roughly one thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (abort_p === 1'b1) aborts++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected image built from the model's field values
  task automatic chk(input int ph, st, rf, tx, ms, bs);
    repeat (2) @(posedge clk);
    apb(1'b0, `I2CBSR_PHASE_OFS, 32'h0);
    cmp("phase register", 32'(ph * 32 + st * 16 + rf * 8 + tx * 4 + ms * 2 + bs), rd);
    cmp("busy output", 32'(bs), {31'h0, busy});
  endtask : chk

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // ********
  // Sequence
  // ********
  initial begin
    do_reset();
    chk(0, 0, 0, 0, 0, 1);
    apb(1'b1, `I2CBSR_CMD_OFS, 32'h1);
    chk(1, 0, 0, 0, 0, 1);
    cmp("start pending", 32'h1, {31'h0, start_pend});
    apb(1'b1, `I2CBSR_CMD_OFS, 32'h2);
    chk(0, 0, 0, 0, 0, 0);
    cmp("abort pulses", 32'h1, aborts);
    cmp("start pending", 32'h0, {31'h0, start_pend});
    apb(1'b1, `I2CBSR_PHASE_OFS, $random(seed));
    cmp("read-only write error", 32'h1, {31'h0, er});
    apb(1'b0, 12'h00c, 32'h0);
    cmp("unmapped read error", 32'h1, {31'h0, er});
    chk(0, 0, 0, 0, 0, 0);
    // Master write with a refused address, then an accepted byte
    apb(1'b1, `I2CBSR_CMD_OFS, 32'h1);
    P.start_cond();
    P.put_byte({7'($random(seed)), 1'b0});
    chk(3, 0, 0, 1, 1, 1);
    P.put_bit(1'b1);
    chk(4, 0, 1, 1, 1, 1);
    hold <= 1'b1;
    P.put_byte(8'($random(seed)));
    chk(5, 1, 0, 1, 1, 1);
    hold <= 1'b0;
    P.put_bit(1'b0);
    chk(6, 0, 0, 1, 1, 1);
    P.stop_cond();
    chk(0, 0, 0, 0, 0, 0);
    // Foreign transfer, slave transmitter with abort, slave receiver
    for (int i = 0; i < 3; i++) begin
      sel <= (i != 0);
      P.start_cond();
      chk(2, 0, 0, 0, 0, 1);
      P.put_byte({7'($random(seed)), i == 1});
      P.put_bit(1'b0);
      P.put_bit(1'b1);
      chk(i ? 5 : 0, 0, 0, i == 1, 0, 1);
      if (i == 1) begin
        apb(1'b1, `I2CBSR_CMD_OFS, 32'h2);
        chk(0, 0, 0, 0, 0, 0);
      end
      P.stop_cond();
      chk(0, 0, 0, 0, 0, 0);
    end
    do_reset();
    chk(0, 0, 0, 0, 0, 1);
    tmo <= 1'b1;
    @(posedge clk);
    tmo <= 1'b0;
    chk(0, 0, 0, 0, 0, 0);
    finish_test();
  end
endmodule : i2c_bus_state_reporting_tb
